// [hw/boost_output_control_regs.v]
// What this block does
// - Sensed coil voltage at peak limit cuts that gate until next period.
// - Slope compensation keeps running while the peak limit acts.
// - One 8-bit linear peak limit per output; code zero allows no current.
// - Output runs only with its enable bit set and operation mode active.
// - Enabled output starts gate supply; switching waits delay and ready flag.
// - Bit 0 clear is configuration mode; set is operation mode with lock.
// - Bit 3 enables chip-select low-time counting.
// - Bit 6 makes supply measurement available before outputs start.
// - Gate supply level comes from low or high register per non-volatile bit.
// - Gate supply ready and gate supply fault flags are reported.
// - Supply is measured continuously, with optional under and overvoltage cut.
// - Measurement register updates when an output is enabled or early bit set.
// - Gate supply protection trip turns supply off and sets fault flag.
`include "boost_ctrl_defs.vh"
module boost_output_control_regs (
   input wire mclk,
   input wire rst,
   input wire reg_wr,
   input wire reg_rd,
   input wire [6:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   input wire nvm_level_select,
   input wire period_start,
   input wire sense_peak_one,
   input wire sense_peak_two,
   input wire gate_supply_good,
   input wire gate_supply_trip,
   input wire [7:0] supply_sample,
   input wire supply_under,
   input wire supply_over,
   input wire protect_enable,
   output reg gate_one,
   output reg gate_two,
   output reg slope_comp_on,
   output reg gate_supply_on,
   output reg [7:0] gate_supply_level,
   output reg [7:0] peak_limit_code_one,
   output reg [7:0] peak_limit_code_two,
   output reg select_low_time_count,
   output reg switching
);
   reg [7:0] function_control;
   reg [7:0] gate_supply_level_low_range;
   reg [7:0] gate_supply_level_high_range;
   reg [7:0] supply_measure;
   reg gate_supply_fault;
   reg gate_supply_ready;
   reg [`STARTUP_CNT_W-1:0] startup_cnt;
   reg nvm_q1, nvm_q2, nvm_q3, nvm_sel;
   reg good_q1, good_q2, good_q3;
   reg trip_q1, trip_q2, trip_q3;
   reg pk1_q1, pk1_q2, pk1_q3;
   reg pk2_q1, pk2_q2, pk2_q3;
   reg per_q1, per_q2, per_q3;
   reg uv_q1, uv_q2, uv_q3;
   reg ov_q1, ov_q2, ov_q3;
   reg supply_cut;
   wire config_done_lock;
   wire output_one_enable;
   wire output_two_enable;
   wire any_enable;
   wire gate_one_raw;
   wire gate_two_raw;
   wire trip_seen;
   wire run_one;
   wire run_two;
   wire stop_supply;
   wire next_switching;
   reg [7:0] next_rdata;

   assign config_done_lock = function_control[`FC_LOCK_BIT];
   assign output_one_enable = function_control[`FC_OUT1_BIT] & config_done_lock;
   assign output_two_enable = function_control[`FC_OUT2_BIT] & config_done_lock;
   assign any_enable = output_one_enable | output_two_enable;
   // Asynchronous inputs are only believed once stages two and three agree.
   assign trip_seen = trip_q2 & trip_q3;
   assign run_one = output_one_enable & switching & ~supply_cut;
   assign run_two = output_two_enable & switching & ~supply_cut;

   // Anything that stops the regulator also stops switching, and the gates with it.
   assign stop_supply = ~any_enable | trip_seen | gate_supply_fault;
   assign next_switching = ~stop_supply & (startup_cnt == `STARTUP_CYCLES)
                           & gate_supply_ready;

   // Three-stage synchronisers for every pin-side input except supply_sample and protect_enable.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         {nvm_q1, nvm_q2, nvm_q3} <= 3'b000;
         {good_q1, good_q2, good_q3} <= 3'b000;
         {trip_q1, trip_q2, trip_q3} <= 3'b000;
         {pk1_q1, pk1_q2, pk1_q3} <= 3'b000;
         {pk2_q1, pk2_q2, pk2_q3} <= 3'b000;
         {per_q1, per_q2, per_q3} <= 3'b000;
         {uv_q1, uv_q2, uv_q3} <= 3'b000;
         {ov_q1, ov_q2, ov_q3} <= 3'b000;
      end else begin
         {nvm_q1, nvm_q2, nvm_q3} <= {nvm_level_select, nvm_q1, nvm_q2};
         {good_q1, good_q2, good_q3} <= {gate_supply_good, good_q1, good_q2};
         {trip_q1, trip_q2, trip_q3} <= {gate_supply_trip, trip_q1, trip_q2};
         {pk1_q1, pk1_q2, pk1_q3} <= {sense_peak_one, pk1_q1, pk1_q2};
         {pk2_q1, pk2_q2, pk2_q3} <= {sense_peak_two, pk2_q1, pk2_q2};
         {per_q1, per_q2, per_q3} <= {period_start, per_q1, per_q2};
         {uv_q1, uv_q2, uv_q3} <= {supply_under, uv_q1, uv_q2};
         {ov_q1, ov_q2, ov_q3} <= {supply_over, ov_q1, ov_q2};
      end
   end

   // The non-volatile select only moves once both late stages agree.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         nvm_sel <= 1'b0;
      end else if (nvm_q2 == nvm_q3) begin
         nvm_sel <= nvm_q3;
      end
   end

   // Register writes; the lock shields configuration but never the function control.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         function_control <= `RST_FUNCTION_CONTROL;
         peak_limit_code_one <= `RST_PEAK_LIMIT;
         peak_limit_code_two <= `RST_PEAK_LIMIT;
         gate_supply_level_low_range <= `RST_GATE_LEVEL_LOW;
         gate_supply_level_high_range <= `RST_GATE_LEVEL_HIGH;
      end else if (reg_wr) begin
         case (reg_addr)
            `ADDR_FUNCTION_CONTROL: begin
               function_control <= reg_wdata;
            end
            `ADDR_PEAK_LIMIT_ONE: begin
               if (!config_done_lock) begin
                  peak_limit_code_one <= reg_wdata;
               end
            end
            `ADDR_PEAK_LIMIT_TWO: begin
               if (!config_done_lock) begin
                  peak_limit_code_two <= reg_wdata;
               end
            end
            `ADDR_GATE_LEVEL_LOW: begin
               if (!config_done_lock) begin
                  gate_supply_level_low_range <= reg_wdata;
               end
            end
            `ADDR_GATE_LEVEL_HIGH: begin
               if (!config_done_lock) begin
                  gate_supply_level_high_range <= reg_wdata;
               end
            end
            default: begin
               function_control <= function_control;
            end
         endcase
      end
   end

   // Chip-select count enable is a registered copy of its control bit.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         select_low_time_count <= 1'b0;
      end else begin
         select_low_time_count <= function_control[`FC_CSCOUNT_BIT];
      end
   end

   // Gate supply level follows the filtered non-volatile select.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         gate_supply_level <= `RST_GATE_LEVEL_LOW;
      end else begin
         gate_supply_level <= nvm_sel ? gate_supply_level_high_range
                                      : gate_supply_level_low_range;
      end
   end

   // Fault flag is sticky; a trip landing with a clearing write wins, so no trip is lost.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         gate_supply_fault <= 1'b0;
      end else if (trip_seen) begin
         gate_supply_fault <= 1'b1;
      end else if (reg_wr && reg_addr == `ADDR_DIAGNOSTIC) begin
         gate_supply_fault <= 1'b0;
      end
   end

   // Ready follows the synchronised good pin only while the regulator is on.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         gate_supply_ready <= 1'b0;
      end else begin
         gate_supply_ready <= good_q2 & good_q3 & gate_supply_on;
      end
   end

   // Start-up counter saturates at the delay count and restarts whenever the supply stops.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         startup_cnt <= {`STARTUP_CNT_W{1'b0}};
      end else if (stop_supply) begin
         startup_cnt <= {`STARTUP_CNT_W{1'b0}};
      end else if (startup_cnt != `STARTUP_CYCLES) begin
         startup_cnt <= startup_cnt + 1'b1;
      end
   end

   // Regulator on with any enabled output; a trip keeps it off until the fault is cleared.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         gate_supply_on <= 1'b0;
         switching <= 1'b0;
      end else begin
         gate_supply_on <= ~stop_supply;
         switching <= next_switching;
      end
   end

   // Supply watch: sample continuously, publish when enabled or early bit set.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         supply_measure <= 8'h00;
         supply_cut <= 1'b0;
      end else begin
         if (any_enable || function_control[`FC_EARLY_MEAS_BIT]) begin
            supply_measure <= supply_sample;
         end
         supply_cut <= protect_enable & ((uv_q2 & uv_q3) | (ov_q2 & ov_q3));
      end
   end

   // Slope compensation runs whenever a phase switches, including under limit.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         slope_comp_on <= 1'b0;
      end else begin
         slope_comp_on <= run_one | run_two;
      end
   end

   // Per-phase gate cut-off; a zero code permits no conduction at all.
   phase_gate_limiter u_phase_one (
      .mclk(mclk),
      .rst(rst),
      .run(run_one && peak_limit_code_one != 8'h00),
      .period_start(per_q2 & per_q3 & ~pk1_q3),
      .peak_reached(pk1_q2 & pk1_q3),
      .gate_on(gate_one_raw)
   );
   phase_gate_limiter u_phase_two (
      .mclk(mclk),
      .rst(rst),
      .run(run_two && peak_limit_code_two != 8'h00),
      .period_start(per_q2 & per_q3 & ~pk2_q3),
      .peak_reached(pk2_q2 & pk2_q3),
      .gate_on(gate_two_raw)
   );

   // Output one is also gated by next_switching, so a gate never outlives switching.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         gate_one <= 1'b0;
      end else begin
         gate_one <= gate_one_raw & run_one & next_switching;
      end
   end

   // Output two mirrors output one with its own limiter and enable.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         gate_two <= 1'b0;
      end else begin
         gate_two <= gate_two_raw & run_two & next_switching;
      end
   end

   // Read multiplexer; unmapped addresses read zero.
   always @* begin
      next_rdata = 8'h00;
      case (reg_addr)
         `ADDR_FUNCTION_CONTROL: next_rdata = function_control;
         `ADDR_GATE_LEVEL_LOW: next_rdata = gate_supply_level_low_range;
         `ADDR_PEAK_LIMIT_ONE: next_rdata = peak_limit_code_one;
         `ADDR_PEAK_LIMIT_TWO: next_rdata = peak_limit_code_two;
         `ADDR_GATE_LEVEL_HIGH: next_rdata = gate_supply_level_high_range;
         `ADDR_SUPPLY_MEASURE: next_rdata = supply_measure;
         `ADDR_DIAGNOSTIC: begin
            next_rdata[`DIAG_GATE_READY_BIT] = gate_supply_ready;
            next_rdata[`DIAG_GATE_FAULT_BIT] = gate_supply_fault;
         end
         default: next_rdata = 8'h00;
      endcase
   end

   // Read data is captured at the edge that samples the read strobe.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end
endmodule // boost_output_control_regs

// [hw/boost_ctrl_defs.vh]
`ifndef BOOST_CTRL_DEFS_VH
`define BOOST_CTRL_DEFS_VH
// Register addresses.
`define ADDR_FUNCTION_CONTROL 7'h00
`define ADDR_GATE_LEVEL_LOW 7'h05
`define ADDR_PEAK_LIMIT_ONE 7'h07
`define ADDR_PEAK_LIMIT_TWO 7'h08
`define ADDR_GATE_LEVEL_HIGH 7'h15
`define ADDR_SUPPLY_MEASURE 7'h45
`define ADDR_DIAGNOSTIC 7'h5f
// Function control bit positions.
`define FC_LOCK_BIT 0
`define FC_OUT1_BIT 1
`define FC_OUT2_BIT 2
`define FC_CSCOUNT_BIT 3
`define FC_EARLY_MEAS_BIT 6
// Diagnostic bit positions.
`define DIAG_GATE_FAULT_BIT 0
`define DIAG_GATE_READY_BIT 5
// Reset values.
`define RST_FUNCTION_CONTROL 8'h00
`define RST_PEAK_LIMIT 8'h00
`define RST_GATE_LEVEL_LOW 8'h80
`define RST_GATE_LEVEL_HIGH 8'h5d
// Peak limit code ceiling kept by software.
`define PEAK_LIMIT_MAX 8'h80
// Start-up delay of the gate drivers, in microseconds, and cycles at 40 MHz.
`define STARTUP_TIME_US 100
`define CLK_MHZ 40
`define STARTUP_CYCLES (`STARTUP_TIME_US * `CLK_MHZ)
`define STARTUP_CNT_W 13
`endif

// [hw/phase_gate_limiter.v]
`include "boost_ctrl_defs.vh"
// One phase: pulse starts each period, peak comparator cuts it until next period.
module phase_gate_limiter (
   input wire mclk,
   input wire rst,
   input wire run,
   input wire period_start,
   input wire peak_reached,
   output reg gate_on
);
   // A cut stays in force until the next period begins.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         gate_on <= 1'b0;
      end else if (!run) begin
         gate_on <= 1'b0;
      end else if (period_start) begin
         gate_on <= 1'b1;
      end else if (peak_reached) begin
         gate_on <= 1'b0;
      end
   end
endmodule // phase_gate_limiter

// [test/boost_output_control_regs_properties.sv]
module boost_output_control_regs_checker (
   input wire mclk,
   input wire rst,
   input wire reg_wr,
   input wire [6:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire sense_peak_one,
   input wire gate_supply_trip,
   input wire gate_one,
   input wire gate_two,
   input wire slope_comp_on,
   input wire gate_supply_on,
   input wire [7:0] peak_limit_code_one,
   input wire select_low_time_count,
   input wire switching,
   input wire protect_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   // Every check shares the one clock, and none holds through a reset.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   property p_gate_one_wait; gate_one |-> switching; endproperty
   a_gate_one_wait: assert property (p_gate_one_wait) else $error("gate one before start-up");
   property p_gate_two_wait; gate_two |-> switching; endproperty
   a_gate_two_wait: assert property (p_gate_two_wait) else $error("gate two before start-up");
   property p_peak_cut; sense_peak_one [*6] |-> !gate_one; endproperty
   a_peak_cut: assert property (p_peak_cut) else $error("gate on at peak limit");
   property p_zero_code; (peak_limit_code_one == 8'h00) [*3] |-> !gate_one; endproperty
   a_zero_code: assert property (p_zero_code) else $error("gate on with zero limit");
   // A supply cut may stop slope compensation, so only cycles clear of protection count.
   property p_slope;
      switching && $past(switching) && !$past(protect_enable, 2) |-> slope_comp_on;
   endproperty
   a_slope: assert property (p_slope) else $error("slope compensation off");
   property p_supply_first; $rose(switching) |-> $past(gate_supply_on, 8); endproperty
   a_supply_first: assert property (p_supply_first) else $error("switching without supply");
   property p_trip_off; gate_supply_trip [*5] |-> !gate_supply_on; endproperty
   a_trip_off: assert property (p_trip_off) else $error("supply on after trip");
   property p_limit_hold;
      !(reg_wr && reg_addr == 7'h07) |=> $stable(peak_limit_code_one);
   endproperty
   a_limit_hold: assert property (p_limit_hold) else $error("limit changed unasked");
   property p_count_bit;
      reg_wr && reg_addr == 7'h00 ##1 !reg_wr |-> ##1 select_low_time_count == $past(reg_wdata[3], 2);
   endproperty
   a_count_bit: assert property (p_count_bit) else $error("count enable wrong");
   c_start: cover property ($rose(switching));
   c_cut: cover property ($fell(gate_one));
   c_trip: cover property (gate_supply_trip && gate_supply_on);
endmodule // boost_output_control_regs_checker
bind boost_output_control_regs boost_output_control_regs_checker checker_inst (
   .mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .sense_peak_one(sense_peak_one), .gate_supply_trip(gate_supply_trip), .gate_one(gate_one),
   .gate_two(gate_two), .slope_comp_on(slope_comp_on), .gate_supply_on(gate_supply_on),
   .peak_limit_code_one(peak_limit_code_one), .select_low_time_count(select_low_time_count),
   .switching(switching), .protect_enable(protect_enable));

// [test/host_model.sv]
module host_model (
   input wire mclk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [6:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 7'h00;
      reg_wdata = 8'h00;
   end
   // Codes are pulled into the accepted ranges, since the device gives no error for them.
   function automatic logic [7:0] legal(input logic [6:0] a, input logic [7:0] d);
      case (a)
         7'h00: legal = d & 8'h4f;
         7'h07, 7'h08: legal = (d > 8'h80) ? 8'h80 : d;
         7'h05: legal = (d < 8'h80) ? 8'h80 : ((d > 8'hb7) ? 8'hb7 : d);
         7'h15: legal = (d < 8'h5d) ? 8'h5d : ((d > 8'hb7) ? 8'hb7 : d);
         default: legal = d;
      endcase
   endfunction
   task write_reg(input logic [6:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= legal(a, d);
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // Read data lands at the edge that samples the strobe and is taken at the next edge.
   task read_reg(input logic [6:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      d = reg_rdata;
   endtask
endmodule // host_model

// [test/test_boost_output_control_regs.sv]
module test_boost_output_control_regs;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [6:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   logic mclk, rst, rd, wr, nvm, per, s1, s2, good, trip;
   logic [6:0] addr;
   logic [7:0] wd, rdata, samp, lvl, pk1, pk2, v;
   logic g1, g2, slope, son, cs, sw;
   logic prot, uv;
   int miscompares = 0;
   int compares = 0;
   int i;
   row_t rows [6] = '{'{7'h07, 8'h40, 8'h40}, '{7'h08, 8'h80, 8'h80}, '{7'h05, 8'hb7, 8'hb7},
      '{7'h15, 8'h70, 8'h70}, '{7'h33, 8'h12, 8'h00}, '{7'h00, 8'h48, 8'h48}};
   logic [6:0] ra [5] = '{7'h00, 7'h05, 7'h07, 7'h08, 7'h15};
   logic [7:0] rv [5] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h5d};
   host_model host_model_inst (.mclk(mclk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
      .reg_wdata(wd), .reg_rdata(rdata));
   boost_output_control_regs boost_output_control_regs_inst (.mclk(mclk), .rst(rst),
      .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdata),
      .nvm_level_select(nvm), .period_start(per), .sense_peak_one(s1), .sense_peak_two(s2),
      .gate_supply_good(good), .gate_supply_trip(trip), .supply_sample(samp),
      .supply_under(uv), .supply_over(1'b0), .protect_enable(prot), .gate_one(g1),
      .gate_two(g2), .slope_comp_on(slope), .gate_supply_on(son), .gate_supply_level(lvl),
      .peak_limit_code_one(pk1), .peak_limit_code_two(pk2), .select_low_time_count(cs),
      .switching(sw));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task check8(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task report_and_stop;
      if (miscompares == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // The start-up wait alone is some 4000 cycles; the limit leaves ample margin.
   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      report_and_stop;
   end
   initial begin
      {rst, nvm, per, s1, s2, good, trip} = 7'h40;
      {prot, uv} = 2'b00;
      samp = 8'h00;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      for (i = 0; i < 5; i++) begin
         host_model_inst.read_reg(ra[i], v);
         check8("reset", rv[i], v);
      end
      check8("level", 8'h80, lvl);
      foreach (rows[k]) begin
         host_model_inst.write_reg(rows[k].a, rows[k].d);
         host_model_inst.read_reg(rows[k].a, v);
         check8("row", rows[k].e, v);
      end
      check8("limits", 8'h40, pk1);
      check8("cscount", 8'h01, cs);
      samp <= 8'h9a;
      host_model_inst.read_reg(7'h45, v);
      check8("measure", 8'h9a, v);
      nvm <= 1'b1;
      repeat (6) @(posedge mclk);
      check8("level_high", 8'h70, lvl);
      nvm <= 1'b0;
      repeat (6) @(posedge mclk);
      check8("level_low", 8'hb7, lvl);
      host_model_inst.write_reg(7'h00, 8'h01);
      host_model_inst.write_reg(7'h07, 8'h10);
      host_model_inst.read_reg(7'h07, v);
      check8("locked", 8'h40, v);
      check8("supply_idle", 8'h00, son);
      good <= 1'b1;
      host_model_inst.write_reg(7'h00, 8'h03);
      repeat (3) @(posedge mclk);
      check8("supply_on", 8'h01, son);
      for (i = 0; i < 5000 && sw !== 1'b1; i++) @(posedge mclk);
      check8("startup", 8'h01, i > 3900 && sw === 1'b1);
      host_model_inst.read_reg(7'h5f, v);
      check8("ready", 8'h20, v & 8'h21);
      per <= 1'b1;
      repeat (3) @(posedge mclk);
      per <= 1'b0;
      repeat (4) @(posedge mclk);
      check8("gates", 8'h02, {g1, g2});
      s1 <= 1'b1;
      repeat (6) @(posedge mclk);
      check8("cut", 8'h00, g1);
      s1 <= 1'b0;
      repeat (8) @(posedge mclk);
      check8("held_off", 8'h00, g1);
      host_model_inst.write_reg(7'h00, 8'h07);
      per <= 1'b1;
      repeat (3) @(posedge mclk);
      per <= 1'b0;
      repeat (4) @(posedge mclk);
      check8("gates_both", 8'h03, {g1, g2});
      check8("slope", 8'h01, slope);
      check8("limit_two", 8'h80, pk2);
      prot <= 1'b1;
      uv <= 1'b1;
      repeat (6) @(posedge mclk);
      check8("uv_cut", 8'h00, {g1, g2});
      uv <= 1'b0;
      prot <= 1'b0;
      trip <= 1'b1;
      good <= 1'b0;
      repeat (6) @(posedge mclk);
      trip <= 1'b0;
      check8("trip_off", 8'h00, son);
      host_model_inst.read_reg(7'h5f, v);
      check8("fault", 8'h01, v & 8'h01);
      host_model_inst.write_reg(7'h5f, 8'h00);
      host_model_inst.read_reg(7'h5f, v);
      check8("cleared", 8'h00, v & 8'h01);
      report_and_stop;
   end
endmodule // test_boost_output_control_regs
